// [hdl/ipm_pin_map.sv]
// Drive pin map, per-drive buffer enables and hidden configuration unlock.
`timescale 1ns/100ps
module ipm_pin_map
	import ipm_pkg::*;
#(
	parameter int STROBE_W = 8
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic io_req,
	input wire ipm_io_t io_cmd,
	output logic io_ack,
	output logic [15:0] io_rdata,
	input wire logic cfg_req,
	input wire ipm_cfg_t cfg_cmd,
	output logic cfg_ack,
	output logic [7:0] cfg_rdata,
	input wire logic per_drive_enables,
	input wire logic no_isa_mode,
	input wire logic [1:0] iface0_role,
	input wire logic [1:0] iface1_role,
	input wire logic periph_cycle,
	input wire logic [7:0] periph_xbus,
	input wire logic [15:0] system_data_in,
	input wire logic [15:0] system_addr_in,
	input wire logic [1:0] drive_channel_ready,
	input wire logic [1:0] drive_dma_request,
	input wire logic clock_strap_25mhz,
	output logic cable0_buffer_enable_n,
	output logic cable1_buffer_enable_n,
	output logic [3:0] drive_buffer_enable_n,
	output logic [7:0] peripheral_xbus,
	output logic drive_read_strobe_n,
	output logic drive_write_strobe_n,
	output logic [15:0] system_data_out,
	output logic system_data_oe,
	output logic [15:0] system_addr_out,
	output logic system_addr_oe,
	output logic mem_read_cmd_n,
	output logic mem_write_cmd_n,
	output logic clock_chip_write_n,
	output logic clock_chip_read_n,
	output logic clock_chip_addr_strobe,
	output logic io_read_cmd_n,
	output logic io_write_cmd_n,
	output logic [1:0] dma_request_out,
	output logic hidden_open,
	output logic master_enable,
	output logic enhanced_fifo,
	output logic prefetch_enable,
	output logic one_ws_read,
	output logic pci_clk_25,
	output logic concurrent_refresh,
	output logic [31:0] bm_io_base
);

	// ------------------------------------------------------------
	// Port decode
	// ------------------------------------------------------------
	function automatic ipm_dec_t ipm_decode(logic [15:0] a);
		ipm_dec_t d;
		logic c0c;
		logic c0t;
		logic c1c;
		logic c1t;
		c0c = (a[15:3] == IPM_C0_CMD_BASE[15:3]);
		c0t = (a[15:1] == IPM_C0_CTL_BASE[15:1]);
		c1c = (a[15:3] == IPM_C1_CMD_BASE[15:3]);
		c1t = (a[15:1] == IPM_C1_CTL_BASE[15:1]);
		d.hit = c0c | c0t | c1c | c1t;
		d.cable = c1c | c1t;
		d.ctl_blk = c0t | c1t;
		d.reg_addr = d.ctl_blk ? {2'b11, a[0]} : a[2:0];
		return d;
	endfunction : ipm_decode

	ipm_state_t state_reg;
	logic [STROBE_W-1:0] count_reg;
	logic cyc_if1_reg;
	logic [1:0] head_drv_reg;
	logic open_once_reg;
	logic open_keep_reg;
	logic lock_forever_reg;
	logic [1:0] unlock_cnt_reg;
	logic strap_taken_reg;
	logic [7:0] timing0_reg;
	logic [7:0] timing1_reg;
	logic [7:0] hid_ctrl_reg;
	logic [7:0] hid_strap_reg;
	logic [7:0] hid_misc_reg;
	logic [7:0] sys_index_reg;
	logic [7:0] feat3_reg;
	logic [7:0] cmd_reg;
	logic [7:0] init_reg;
	logic [7:0] refresh_reg;
	logic [31:0] bar_reg;

	ipm_dec_t dec;
	ipm_ctl_t start_ctl;
	logic take;
	logic open_now;
	logic hid_sel;
	logic sys_sel;
	logic go_if0;
	logic go_if1;
	logic drive_cyc;
	logic cable_sel;
	logic [1:0] role_sel;
	logic [7:0] wbyte;
	logic [STROBE_W-1:0] start_count;
	logic [7:0] hid_rdata;
	logic cfg_hit;
	logic strobe_done;

	// ------------------------------------------------------------
	// Request decode
	// ------------------------------------------------------------
	always_comb begin
		dec = ipm_decode(io_cmd.addr);
		take = io_req && (state_reg == IPM_IDLE);
		strobe_done = (state_reg == IPM_STROBE) && (count_reg == '0) &&
			drive_channel_ready[cyc_if1_reg];
		open_now = open_once_reg | open_keep_reg;
		wbyte = io_cmd.wdata[7:0];
		hid_sel = take && open_now && !io_cmd.dma &&
			(io_cmd.addr == IPM_HID_TIMING || io_cmd.addr == IPM_HID_LOCK ||
			io_cmd.addr == IPM_HID_CTRL || io_cmd.addr == IPM_HID_STRAP ||
			io_cmd.addr == IPM_HID_MISC);
		sys_sel = take && !io_cmd.dma &&
			(io_cmd.addr == IPM_SYS_INDEX_PORT || io_cmd.addr == IPM_SYS_DATA_PORT);
		cable_sel = io_cmd.dma ? io_cmd.dma_cable : dec.cable;
		role_sel = {cable_sel, head_drv_reg[cable_sel]};
		drive_cyc = take && !hid_sel && (dec.hit || io_cmd.dma);
		if (no_isa_mode) begin
			go_if0 = (iface0_role == role_sel);
			go_if1 = !go_if0 && (iface1_role == role_sel);
		end else begin
			go_if0 = 1'b1;
			go_if1 = 1'b0;
		end
		start_ctl.cs3_n = !(dec.hit && dec.ctl_blk && !io_cmd.dma);
		start_ctl.cs1_n = !(dec.hit && !dec.ctl_blk && !io_cmd.dma);
		start_ctl.dack_n = !io_cmd.dma;
		start_ctl.addr = io_cmd.dma ? 3'h0 : dec.reg_addr;
		start_ctl.rd_n = io_cmd.write;
		start_ctl.wr_n = !io_cmd.write;
		if (io_cmd.write) begin
			start_count = STROBE_W'(hid_misc_reg[IPM_MISC_TSEL_BIT] ?
				timing1_reg : timing0_reg);
		end else begin
			start_count = STROBE_W'(hid_ctrl_reg[IPM_CTRL_1WS_BIT] ?
				IPM_RD_WS_FAST : IPM_RD_WS_SLOW);
		end
		unique case (io_cmd.addr)
			IPM_HID_TIMING: hid_rdata = hid_misc_reg[IPM_MISC_TSEL_BIT] ?
				timing1_reg : timing0_reg;
			IPM_HID_CTRL: hid_rdata = hid_ctrl_reg;
			IPM_HID_STRAP: hid_rdata = hid_strap_reg;
			IPM_HID_MISC: hid_rdata = hid_misc_reg;
			default: hid_rdata = 8'h00;
		endcase
		if (cfg_cmd.bridge) begin
			cfg_hit = 1'b1;
		end else if (feat3_reg[IPM_FEAT3_ID_BIT]) begin
			cfg_hit = (cfg_cmd.dev == IPM_DEV_B) && (cfg_cmd.func == IPM_FUNC_B);
		end else begin
			cfg_hit = (cfg_cmd.dev == IPM_DEV_A) && (cfg_cmd.func == IPM_FUNC_A);
		end
	end

	// ------------------------------------------------------------
	// Drive cycle sequencer and pin drive
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= IPM_IDLE;
			count_reg <= '0;
			cyc_if1_reg <= 1'b0;
			io_ack <= 1'b0;
			io_rdata <= 16'h0000;
			// All pins low so a drive that may be unpowered is not fed.
			cable0_buffer_enable_n <= 1'b0;
			cable1_buffer_enable_n <= 1'b0;
			drive_buffer_enable_n <= 4'h0;
			peripheral_xbus <= 8'h00;
			drive_read_strobe_n <= 1'b0;
			drive_write_strobe_n <= 1'b0;
			system_data_out <= 16'h0000;
			system_data_oe <= 1'b0;
			system_addr_out <= 16'h0000;
			system_addr_oe <= 1'b0;
			{mem_read_cmd_n, mem_write_cmd_n} <= 2'h0;
			{clock_chip_write_n, clock_chip_read_n} <= 2'h0;
			clock_chip_addr_strobe <= 1'b0;
			{io_read_cmd_n, io_write_cmd_n} <= 2'h0;
		end else begin
			io_ack <= 1'b0;
			// Pins fall idle on the edge that ends a strobe, with io_ack.
			if (state_reg == IPM_IDLE || strobe_done) begin
				cable0_buffer_enable_n <= 1'b1;
				cable1_buffer_enable_n <= 1'b1;
				drive_buffer_enable_n <= 4'hF;
				drive_read_strobe_n <= 1'b1;
				drive_write_strobe_n <= 1'b1;
				system_data_oe <= 1'b0;
				system_addr_oe <= 1'b0;
				{mem_read_cmd_n, mem_write_cmd_n} <= 2'h3;
				{clock_chip_write_n, clock_chip_read_n} <= 2'h3;
				clock_chip_addr_strobe <= 1'b0;
				{io_read_cmd_n, io_write_cmd_n} <= 2'h3;
				// X-bus may carry peripheral cycles; drive strobes stay idle.
				if (periph_cycle && !no_isa_mode) begin
					peripheral_xbus <= periph_xbus;
				end else begin
					peripheral_xbus <= IPM_CTL_IDLE;
				end
			end
			unique case (state_reg)
				IPM_IDLE: begin
					if (drive_cyc && (go_if0 || go_if1)) begin
						state_reg <= IPM_STROBE;
						count_reg <= start_count;
						cyc_if1_reg <= go_if1;
						if (go_if1) begin
							// Second interface on the freed ISA pins.
							{mem_read_cmd_n, mem_write_cmd_n} <=
								{start_ctl.cs3_n, start_ctl.cs1_n};
							cable0_buffer_enable_n <= start_ctl.dack_n;
							clock_chip_write_n <= start_ctl.addr[2];
							clock_chip_read_n <= start_ctl.addr[1];
							clock_chip_addr_strobe <= start_ctl.addr[0];
							io_read_cmd_n <= start_ctl.rd_n;
							io_write_cmd_n <= start_ctl.wr_n;
							system_addr_out <= io_cmd.wdata;
							system_addr_oe <= io_cmd.write;
						end else begin
							peripheral_xbus <= start_ctl;
							drive_read_strobe_n <= start_ctl.rd_n;
							drive_write_strobe_n <= start_ctl.wr_n;
							system_data_out <= io_cmd.wdata;
							system_data_oe <= io_cmd.write;
							if (!no_isa_mode) begin
								cable0_buffer_enable_n <= cable_sel;
								cable1_buffer_enable_n <= !cable_sel;
								if (per_drive_enables) begin
									drive_buffer_enable_n <= ~(4'h1 << role_sel);
								end
							end
						end
					end else if (take) begin
						io_ack <= 1'b1;
						if (hid_sel) begin
							io_rdata <= {8'h00, hid_rdata};
						end else if (sys_sel) begin
							io_rdata <= {8'h00,
								(io_cmd.addr == IPM_SYS_INDEX_PORT) ? sys_index_reg :
								(sys_index_reg == IPM_SYS_FEAT3) ? feat3_reg : 8'h00};
						end else begin
							io_rdata <= 16'h0000;
						end
					end
				end
				IPM_STROBE: begin
					// Strobe ends once the count runs out and the drive is ready.
					if (count_reg != '0) begin
						count_reg <= count_reg - 1'b1;
					end else if (strobe_done) begin
						state_reg <= IPM_IDLE;
						io_ack <= 1'b1;
						io_rdata <= cyc_if1_reg ? system_addr_in : system_data_in;
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Drive select memory and DMA request pass-through
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			head_drv_reg <= 2'h0;
			dma_request_out <= 2'h0;
		end else begin
			dma_request_out <= drive_dma_request;
			if (take && io_cmd.write && !hid_sel) begin
				if (io_cmd.addr == IPM_C0_HEAD_PORT) begin
					head_drv_reg[0] <= wbyte[IPM_HEAD_DRV_BIT];
				end
				if (io_cmd.addr == IPM_C1_HEAD_PORT) begin
					head_drv_reg[1] <= wbyte[IPM_HEAD_DRV_BIT];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Hidden space unlock and lock
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			open_once_reg <= 1'b0;
			open_keep_reg <= 1'b0;
			lock_forever_reg <= 1'b0;
			unlock_cnt_reg <= 2'h0;
			hidden_open <= 1'b0;
		end else begin
			hidden_open <= open_once_reg | open_keep_reg;
			if (take) begin
				if (open_once_reg) begin
					open_once_reg <= 1'b0;
				end
				if (hid_sel && io_cmd.write && io_cmd.addr == IPM_HID_LOCK &&
						wbyte[1:0] == IPM_LOCK_KEY) begin
					if (wbyte[IPM_LOCK_OFF_BIT]) begin
						open_keep_reg <= 1'b0;
						lock_forever_reg <= 1'b1;
					end else if (wbyte[IPM_LOCK_HIDE_BIT]) begin
						open_keep_reg <= 1'b0;
					end else begin
						open_keep_reg <= 1'b1;
					end
				end
				if (!open_now && !lock_forever_reg) begin
					if (!io_cmd.write && io_cmd.size16 && !io_cmd.dma &&
							io_cmd.addr == IPM_HID_TIMING) begin
						if (unlock_cnt_reg == IPM_UNLOCK_READS - 2'h1) begin
							open_once_reg <= 1'b1;
							unlock_cnt_reg <= 2'h0;
						end else begin
							unlock_cnt_reg <= unlock_cnt_reg + 2'h1;
						end
					end else if (dec.hit || io_cmd.dma) begin
						unlock_cnt_reg <= 2'h0;
					end
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Hidden registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			timing0_reg <= IPM_HID_RST;
			timing1_reg <= IPM_HID_RST;
			hid_ctrl_reg <= IPM_HID_RST;
			hid_strap_reg <= IPM_HID_RST;
			hid_misc_reg <= IPM_HID_RST;
			strap_taken_reg <= 1'b0;
		end else begin
			if (!strap_taken_reg) begin
				strap_taken_reg <= 1'b1;
				hid_strap_reg[IPM_STRAP_CLK_BIT] <= clock_strap_25mhz;
			end else if (hid_sel && io_cmd.write && io_cmd.addr == IPM_HID_STRAP) begin
				hid_strap_reg <= wbyte;
			end
			if (hid_sel && io_cmd.write) begin
				if (io_cmd.addr == IPM_HID_TIMING) begin
					if (hid_misc_reg[IPM_MISC_TSEL_BIT]) begin
						timing1_reg <= wbyte;
					end else begin
						timing0_reg <= wbyte;
					end
				end
				if (io_cmd.addr == IPM_HID_CTRL) begin
					hid_ctrl_reg <= wbyte;
				end
				if (io_cmd.addr == IPM_HID_MISC) begin
					hid_misc_reg <= wbyte;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// System configuration and PCI configuration registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sys_index_reg <= 8'h00;
			feat3_reg <= 8'h00;
			cmd_reg <= IPM_CMD_RST;
			init_reg <= 8'h00;
			refresh_reg <= 8'h00;
			bar_reg <= IPM_BAR_RST;
			cfg_ack <= 1'b0;
			cfg_rdata <= 8'h00;
		end else begin
			if (sys_sel && io_cmd.write) begin
				if (io_cmd.addr == IPM_SYS_INDEX_PORT) begin
					sys_index_reg <= wbyte;
				end else if (sys_index_reg == IPM_SYS_FEAT3) begin
					feat3_reg <= wbyte;
				end
			end
			cfg_ack <= cfg_req;
			if (cfg_req) begin
				cfg_rdata <= 8'h00;
				if (cfg_hit && cfg_cmd.bridge) begin
					if (cfg_cmd.off == IPM_BRG_REFRESH) begin
						cfg_rdata <= refresh_reg;
						if (cfg_cmd.write) begin
							refresh_reg <= cfg_cmd.wdata;
						end
					end
				end else if (cfg_hit) begin
					unique case (cfg_cmd.off)
						IPM_CFG_CMD: begin
							cfg_rdata <= cmd_reg;
							if (cfg_cmd.write) begin
								cmd_reg <= cfg_cmd.wdata;
							end
						end
						IPM_CFG_INIT: begin
							cfg_rdata <= init_reg;
							if (cfg_cmd.write) begin
								init_reg <= cfg_cmd.wdata;
							end
						end
						IPM_CFG_BAR: begin
							cfg_rdata <= bar_reg[7:0];
							if (cfg_cmd.write) begin
								bar_reg[7:0] <= {cfg_cmd.wdata[7:4], IPM_BAR_LOW};
							end
						end
						IPM_CFG_BAR + 8'h01: begin
							cfg_rdata <= bar_reg[15:8];
							if (cfg_cmd.write) begin
								bar_reg[15:8] <= cfg_cmd.wdata;
							end
						end
						IPM_CFG_BAR + 8'h02: begin
							cfg_rdata <= bar_reg[23:16];
							if (cfg_cmd.write) begin
								bar_reg[23:16] <= cfg_cmd.wdata;
							end
						end
						IPM_CFG_BAR + 8'h03: begin
							cfg_rdata <= bar_reg[31:24];
							if (cfg_cmd.write) begin
								bar_reg[31:24] <= cfg_cmd.wdata;
							end
						end
						default: cfg_rdata <= 8'h00;
					endcase
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Registered setup outputs
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			master_enable <= 1'b0;
			enhanced_fifo <= 1'b0;
			prefetch_enable <= 1'b0;
			one_ws_read <= 1'b0;
			pci_clk_25 <= 1'b0;
			concurrent_refresh <= 1'b0;
			bm_io_base <= IPM_BAR_RST;
		end else begin
			master_enable <= cmd_reg[IPM_CMD_MASTER_BIT];
			enhanced_fifo <= init_reg[IPM_INIT_FIFO_BIT];
			prefetch_enable <= hid_misc_reg[IPM_MISC_PREF_BIT];
			one_ws_read <= hid_ctrl_reg[IPM_CTRL_1WS_BIT];
			pci_clk_25 <= hid_strap_reg[IPM_STRAP_CLK_BIT];
			concurrent_refresh <= refresh_reg[IPM_REFRESH_BIT];
			bm_io_base <= bar_reg;
		end
	end

endmodule : ipm_pin_map

// [pkg/ipm_pkg.sv]
// Constants and types for the drive pin map and configuration unlock block.
package ipm_pkg;

	// ------------------------------------------------------------
	// Drive port map
	// ------------------------------------------------------------
	localparam logic [15:0] IPM_C0_CMD_BASE = 16'h01F0;
	localparam logic [15:0] IPM_C0_CTL_BASE = 16'h03F6;
	localparam logic [15:0] IPM_C1_CMD_BASE = 16'h0170;
	localparam logic [15:0] IPM_C1_CTL_BASE = 16'h0376;
	localparam logic [15:0] IPM_C0_HEAD_PORT = 16'h01F6;
	localparam logic [15:0] IPM_C1_HEAD_PORT = 16'h0176;
	localparam int IPM_HEAD_DRV_BIT = 4;

	// ------------------------------------------------------------
	// System configuration index and data ports
	// ------------------------------------------------------------
	localparam logic [15:0] IPM_SYS_INDEX_PORT = 16'h0022;
	localparam logic [15:0] IPM_SYS_DATA_PORT = 16'h0024;
	localparam logic [7:0] IPM_SYS_FEAT3 = 8'hAD;
	localparam int IPM_FEAT3_ID_BIT = 4;

	// ------------------------------------------------------------
	// Hidden registers behind the drive ports
	// ------------------------------------------------------------
	localparam logic [15:0] IPM_HID_TIMING = 16'h01F1;
	localparam logic [15:0] IPM_HID_LOCK = 16'h01F2;
	localparam logic [15:0] IPM_HID_CTRL = 16'h01F3;
	localparam logic [15:0] IPM_HID_STRAP = 16'h01F5;
	localparam logic [15:0] IPM_HID_MISC = 16'h01F6;
	localparam int IPM_LOCK_HIDE_BIT = 7;
	localparam int IPM_LOCK_OFF_BIT = 6;
	localparam logic [1:0] IPM_LOCK_KEY = 2'h3;
	localparam logic [1:0] IPM_UNLOCK_READS = 2'h2;
	localparam int IPM_CTRL_1WS_BIT = 4;
	localparam int IPM_STRAP_CLK_BIT = 0;
	localparam int IPM_MISC_PREF_BIT = 6;
	localparam int IPM_MISC_TSEL_BIT = 0;
	localparam logic [7:0] IPM_HID_RST = 8'h00;

	// ------------------------------------------------------------
	// PCI configuration space
	// ------------------------------------------------------------
	localparam logic [7:0] IPM_CFG_CMD = 8'h04;
	localparam logic [7:0] IPM_CFG_BAR = 8'h20;
	localparam logic [7:0] IPM_CFG_INIT = 8'h40;
	localparam logic [7:0] IPM_BRG_REFRESH = 8'h52;
	localparam logic [7:0] IPM_CMD_RST = 8'h45;
	localparam logic [31:0] IPM_BAR_RST = 32'h00000001;
	localparam logic [3:0] IPM_BAR_LOW = 4'h1;
	localparam int IPM_CMD_MASTER_BIT = 2;
	localparam int IPM_INIT_FIFO_BIT = 5;
	localparam int IPM_REFRESH_BIT = 0;
	localparam logic [4:0] IPM_DEV_A = 5'h14;
	localparam logic [2:0] IPM_FUNC_A = 3'h0;
	localparam logic [4:0] IPM_DEV_B = 5'h01;
	localparam logic [2:0] IPM_FUNC_B = 3'h1;

	// ------------------------------------------------------------
	// Strobe timing
	// ------------------------------------------------------------
	localparam logic [7:0] IPM_RD_WS_SLOW = 8'h02;
	localparam logic [7:0] IPM_RD_WS_FAST = 8'h01;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		logic cs3_n;
		logic cs1_n;
		logic dack_n;
		logic [2:0] addr;
		logic rd_n;
		logic wr_n;
	} ipm_ctl_t;
	localparam ipm_ctl_t IPM_CTL_IDLE = 8'hE3;

	typedef struct packed {
		logic write;
		logic size16;
		logic dma;
		logic dma_cable;
		logic [15:0] addr;
		logic [15:0] wdata;
	} ipm_io_t;

	typedef struct packed {
		logic write;
		logic bridge;
		logic [4:0] dev;
		logic [2:0] func;
		logic [7:0] off;
		logic [7:0] wdata;
	} ipm_cfg_t;

	typedef struct packed {
		logic hit;
		logic cable;
		logic ctl_blk;
		logic [2:0] reg_addr;
	} ipm_dec_t;

	typedef enum logic {IPM_IDLE, IPM_STROBE} ipm_state_t;

endpackage : ipm_pkg

// [verification/ipm_pin_map_monitor.sv]
// Port assertions for the drive pin map and configuration unlock block.
`timescale 1ns/100ps
module ipm_pin_map_monitor
	import ipm_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic io_req,
	input wire ipm_io_t io_cmd,
	input wire logic no_isa_mode,
	input wire logic per_drive_enables,
	input wire logic cable0_buffer_enable_n,
	input wire logic cable1_buffer_enable_n,
	input wire logic drive_write_strobe_n,
	input wire logic drive_read_strobe_n,
	input wire logic [7:0] peripheral_xbus,
	input wire logic hidden_open,
	input wire logic master_enable,
	input wire logic [31:0] bm_io_base
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	logic locked_reg;
	wire logic std_io = io_req && !io_cmd.dma && !no_isa_mode && !per_drive_enables;
	wire logic lk_wr = io_req && io_cmd.write && io_cmd.addr == IPM_HID_LOCK && hidden_open;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			locked_reg <= 1'b0;
		end else if (lk_wr && io_cmd.wdata[7:0] == 8'hC3) begin
			locked_reg <= 1'b1;
		end
	end
	property p_bar; bm_io_base[3:0] == IPM_BAR_LOW; endproperty
	a_bar: assert property (p_bar) else $error("base low bits");
	property p_me; $rose(rst_b) |=> master_enable; endproperty
	a_me: assert property (p_me) else $error("master reset");
	property p_c0; std_io && io_cmd.addr inside {16'h01F0, 16'h01F7,
		16'h03F6, 16'h03F7} |=> !cable0_buffer_enable_n; endproperty
	a_c0: assert property (p_c0) else $error("cable0 enable");
	property p_c1; std_io && io_cmd.addr inside {16'h0170, 16'h0177,
		16'h0376, 16'h0377} |=> !cable1_buffer_enable_n; endproperty
	a_c1: assert property (p_c1) else $error("cable1 enable");
	property p_idle; !no_isa_mode && cable0_buffer_enable_n &&
		cable1_buffer_enable_n |-> drive_read_strobe_n && drive_write_strobe_n;
	endproperty
	a_idle: assert property (p_idle) else $error("stray strobe");
	property p_wr; $past(rst_b) && !drive_write_strobe_n |->
		peripheral_xbus[1:0] == 2'h2;
	endproperty
	a_wr: assert property (p_wr) else $error("xbus strobes");
	property p_lock; locked_reg |-> ##2 !hidden_open; endproperty
	a_lock: assert property (p_lock) else $error("reopened");
	property p_hide; lk_wr && io_cmd.wdata[7] && io_cmd.wdata[1:0] == 2'h3
		|-> ##[1:4] !hidden_open; endproperty
	a_hide: assert property (p_hide) else $error("not hidden");
	property p_keep; lk_wr && io_cmd.wdata[7:0] == 8'h03 |=> hidden_open[*3];
	endproperty
	a_keep: assert property (p_keep) else $error("not kept");
	c_open: cover property ($rose(hidden_open));
	c_wr: cover property ($fell(drive_write_strobe_n));
	c_lock: cover property ($rose(locked_reg));
endmodule : ipm_pin_map_monitor
bind ipm_pin_map ipm_pin_map_monitor ipm_pin_map_monitor_i (.clk, .rst_b,
	.io_req, .io_cmd, .no_isa_mode, .per_drive_enables,
	.cable0_buffer_enable_n, .cable1_buffer_enable_n, .drive_write_strobe_n,
	.drive_read_strobe_n, .peripheral_xbus, .hidden_open, .master_enable,
	.bm_io_base);

// [verification/ipm_drive_model.sv]
// Behavioural drive on the first physical interface.
`timescale 1ns/100ps
module ipm_drive_model #(
	parameter logic [15:0] RD_WORD = 16'hA55A
) (
	input wire logic clk,
	input wire logic strobe_n,
	input wire logic slow,
	output logic ready,
	output logic [15:0] rdata
);
	logic [2:0] wait_reg = 3'h0;
	logic [15:0] word_reg = 16'h0000;
	// Idle data keeps changing so that a stale sample cannot match.
	always_ff @(posedge clk) begin
		word_reg <= strobe_n ? ~word_reg : RD_WORD;
		wait_reg <= strobe_n ? (slow ? 3'h6 : 3'h0) :
			wait_reg - {2'h0, wait_reg != 3'h0};
	end
	assign rdata = word_reg;
	assign ready = strobe_n || wait_reg == 3'h0;
endmodule : ipm_drive_model

// [verification/tb_top.sv]
// Self-checking bench for the drive pin map and configuration unlock.
`timescale 1ns/100ps
module tb_top;
	import ipm_pkg::*;
	logic clk, rst_b, io_req, cfg_req, per_drive_enables, no_isa_mode;
	logic periph_cycle, io_ack, cfg_ack, d_wr_n, d_rd_n, hidden_open, slow;
	logic master_enable, enhanced_fifo, prefetch_enable, one_ws_read;
	logic pci_clk_25, rdy0;
	ipm_io_t io_cmd;
	ipm_cfg_t cfg_cmd;
	logic [1:0] iface0_role, iface1_role;
	logic [7:0] periph_xbus, xbus, cfg_rdata;
	logic [15:0] sd_in, io_rdata;
	logic [31:0] bm_io_base;
	logic [3:0] dbe_n, dbe_seen;
	int fails = 0, n_tests = 0, cyc = 0, wcnt, rcnt;
	ipm_pin_map ipm_pin_map_i (.clk, .rst_b, .io_req, .io_cmd, .io_ack,
		.io_rdata, .cfg_req, .cfg_cmd, .cfg_ack, .cfg_rdata, .per_drive_enables,
		.no_isa_mode, .iface0_role, .iface1_role, .periph_cycle, .periph_xbus,
		.system_data_in(sd_in), .system_addr_in(16'h0000),
		.drive_channel_ready({1'b1, rdy0}), .drive_dma_request(2'h0),
		.clock_strap_25mhz(1'b0), .cable0_buffer_enable_n(),
		.cable1_buffer_enable_n(), .drive_buffer_enable_n(dbe_n),
		.peripheral_xbus(xbus), .drive_read_strobe_n(d_rd_n),
		.drive_write_strobe_n(d_wr_n), .system_data_out(), .system_data_oe(),
		.system_addr_out(), .system_addr_oe(), .mem_read_cmd_n(),
		.mem_write_cmd_n(), .clock_chip_write_n(), .clock_chip_read_n(),
		.clock_chip_addr_strobe(), .io_read_cmd_n(), .io_write_cmd_n(),
		.dma_request_out(), .hidden_open, .master_enable, .enhanced_fifo,
		.prefetch_enable, .one_ws_read, .pci_clk_25, .concurrent_refresh(),
		.bm_io_base);
	ipm_drive_model ipm_drive_model_i (.clk, .strobe_n(d_rd_n & d_wr_n),
		.slow, .ready(rdy0), .rdata(sd_in));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			fails++;
			print_verdict();
		end
	end
	task automatic check(input string what, input logic [31:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic io(input logic w, input logic [15:0] a, d);
		@(posedge clk);
		io_req <= 1'b1;
		io_cmd <= '{w, a[3:0] == 4'h0 || (!w && a == IPM_HID_TIMING), 1'b0,
			1'b0, a, d};
		@(posedge clk);
		io_req <= 1'b0;
		wcnt = 0;
		rcnt = 0;
		for (int n = 0; n < 40; n++) begin
			#1;
			if (io_ack === 1'b1) break;
			wcnt += int'(d_wr_n === 1'b0);
			rcnt += int'(d_rd_n === 1'b0);
			if (!(d_rd_n & d_wr_n)) dbe_seen = dbe_n;
			@(posedge clk);
		end
		check("io_ack", io_ack, 1'b1);
		check("idle", {d_rd_n, d_wr_n}, 2'h3);
		if (!w) check("io_rdata", io_rdata[7:0], d[7:0]);
	endtask : io
	task automatic cfg(input logic w, b, input logic [4:0] dv,
		input logic [7:0] o, d);
		@(posedge clk);
		cfg_req <= 1'b1;
		cfg_cmd <= '{w, b, dv, (dv == 5'h01) ? 3'h1 : 3'h0, o, d};
		@(posedge clk);
		cfg_req <= 1'b0;
		#1;
		check("cfg_ack", cfg_ack, 1'b1);
		if (!w) check("cfg_rdata", cfg_rdata, d);
	endtask : cfg
	task automatic settle();
		repeat (3) @(posedge clk);
		#1;
	endtask : settle
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : print_verdict
	initial begin
		{rst_b, io_req, cfg_req, per_drive_enables, periph_cycle, slow} = '0;
		{io_cmd, cfg_cmd, iface0_role, iface1_role} = '0;
		no_isa_mode = 1'b1;
		periph_xbus = 8'h5A;
		repeat (2) @(posedge clk);
		#1;
		check("reset_xbus", xbus, 8'h00);
		@(posedge clk);
		rst_b <= 1'b1;
		no_isa_mode <= 1'b0;
		settle();
		check("master", master_enable, 1'b1);
		check("bm_base", bm_io_base, IPM_BAR_RST);
		$display("test reset done");
		io(1'b1, 16'h01F0, 16'h1234);
		check("wr_width", wcnt, 1);
		io(1'b0, 16'h01F0, 16'h005A);
		check("rd_width", rcnt, 3);
		io(1'b1, 16'h0170, 16'h0000);
		slow <= 1'b1;
		io(1'b0, 16'h0377, 16'h005A);
		slow <= 1'b0;
		periph_cycle <= 1'b1;
		settle();
		check("periph", {xbus, d_rd_n, d_wr_n}, 10'h16B);
		periph_cycle <= 1'b0;
		$display("test drive cycles done");
		io(1'b0, IPM_HID_TIMING, 16'h005A);
		io(1'b0, IPM_HID_TIMING, 16'h005A);
		io(1'b1, IPM_HID_LOCK, 16'h0003);
		io(1'b1, IPM_HID_TIMING, 16'h0003);
		io(1'b1, IPM_HID_CTRL, 16'h0010);
		io(1'b1, IPM_HID_MISC, 16'h0040);
		io(1'b1, IPM_HID_STRAP, 16'h0001);
		io(1'b1, IPM_HID_LOCK, 16'h0080);
		io(1'b0, IPM_HID_CTRL, 16'h0010);
		check("kept", hidden_open, 1'b1);
		io(1'b1, IPM_HID_LOCK, 16'h0083);
		settle();
		check("hidden", hidden_open, 1'b0);
		check("hid_bits", {prefetch_enable, one_ws_read, pci_clk_25}, 3'h7);
		io(1'b1, 16'h01F0, 16'h0000);
		check("wr_width", wcnt, 4);
		io(1'b0, 16'h01F0, 16'h005A);
		check("rd_width", rcnt, 2);
		io(1'b0, IPM_HID_TIMING, 16'h005A);
		io(1'b1, 16'h01F0, 16'h0000);
		io(1'b0, IPM_HID_TIMING, 16'h005A);
		settle();
		check("broken_pair", hidden_open, 1'b0);
		io(1'b0, IPM_HID_TIMING, 16'h005A);
		settle();
		check("opened", hidden_open, 1'b1);
		io(1'b0, IPM_HID_CTRL, 16'h0010);
		settle();
		check("one_shot", hidden_open, 1'b0);
		io(1'b0, IPM_HID_TIMING, 16'h005A);
		io(1'b0, IPM_HID_TIMING, 16'h005A);
		io(1'b1, IPM_HID_LOCK, 16'h00C3);
		io(1'b0, IPM_HID_TIMING, 16'h005A);
		io(1'b0, IPM_HID_TIMING, 16'h005A);
		settle();
		check("locked", hidden_open, 1'b0);
		$display("test unlock done");
		per_drive_enables <= 1'b1;
		io(1'b1, 16'h01F6, 16'h0010);
		io(1'b0, 16'h01F0, 16'h005A);
		check("drive_en", dbe_seen, 4'hD);
		{no_isa_mode, iface1_role} <= 3'h5;
		io(1'b0, 16'h01F0, 16'h0000);
		check("if1_cycle", rcnt, 0);
		{no_isa_mode, per_drive_enables} <= 2'h0;
		cfg(1'b0, 1'b0, 5'h14, IPM_CFG_CMD, IPM_CMD_RST);
		cfg(1'b1, 1'b0, 5'h14, IPM_CFG_BAR, 8'hFF);
		cfg(1'b0, 1'b0, 5'h14, IPM_CFG_BAR, 8'hF1);
		cfg(1'b1, 1'b0, 5'h14, IPM_CFG_INIT, 8'h20);
		cfg(1'b1, 1'b0, 5'h14, IPM_CFG_CMD, 8'h41);
		cfg(1'b1, 1'b1, 5'h00, IPM_BRG_REFRESH, 8'h01);
		settle();
		check("cfg_bits", {enhanced_fifo, master_enable}, 2'h2);
		io(1'b1, IPM_SYS_INDEX_PORT, {8'h00, IPM_SYS_FEAT3});
		io(1'b1, IPM_SYS_DATA_PORT, 16'h0010);
		io(1'b0, IPM_SYS_DATA_PORT, 16'h0010);
		cfg(1'b0, 1'b0, 5'h14, IPM_CFG_INIT, 8'h00);
		cfg(1'b0, 1'b0, 5'h01, IPM_CFG_INIT, 8'h20);
		$display("test config done");
		print_verdict();
	end
endmodule : tb_top
